// file: hdl/psfw_check.sv
`timescale 1ns/10ps
`include "psfw_defines.svh"
// Membership lookup on the doubled tag
module psfw_check (
  input wire logic [`PSFW_TAG_W-1:0] initiator_tag_i,
  input wire logic [31:0] group_member_mask_i,
  output logic [`PSFW_DTAG_W-1:0] doubled_initiator_tag_o,
  output logic permit_o
);
  // Tag arrives shifted one place left
  assign doubled_initiator_tag_o = {initiator_tag_i, 1'b0}; // R2
  // Mask bit selected by the doubled tag
  assign permit_o = group_member_mask_i[doubled_initiator_tag_o]; // R1
endmodule

// file: hdl/psfw_defines.svh
`ifndef PSFW_DEFINES_SVH
`define PSFW_DEFINES_SVH
// Register offsets (byte addresses on the plain port)
`define PSFW_OFF_MEMBER 8'h00
`define PSFW_OFF_ERR_TAG 8'h04
`define PSFW_OFF_ERR_STAT 8'h08
`define PSFW_OFF_ERR_ADDR 8'h0C
// Reset value: upper half of the membership mask is zero
`define PSFW_MEMBER_RST 32'h0000_FFFF
// Field positions in the error status word
`define PSFW_STAT_VALID 0
`define PSFW_STAT_WRITE 1
`define PSFW_STAT_OVFL 2
// Widths
`define PSFW_TAG_W 4
`define PSFW_DTAG_W 5
`define PSFW_ADDR_W 16
`endif

// file: hdl/psfw_firewall.sv
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/10ps
`include "psfw_defines.svh"
// Behaviour
// (R1) Permit each access by initiator tag membership
// (R2) Use the tag doubled by one-bit shift
// (R3) Log violations with the doubled tag
// (R4) Mask upper half resets to zero
// (R5) Tags eight and above denied after reset
// (R6) Software sets bit twice tag, halves log
// (R7) Denied access blocked, error returned
module psfw_firewall (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // Initiator side
  input wire logic acc_valid_i,
  input wire logic acc_write_i,
  input wire logic [`PSFW_TAG_W-1:0] initiator_tag_i,
  input wire logic [`PSFW_ADDR_W-1:0] acc_addr_i,
  input wire logic [31:0] acc_wdata_i,
  output logic acc_ready_o,
  output logic acc_resp_valid_o,
  output logic acc_resp_err_o,
  output logic [31:0] acc_rdata_o,
  // Target side
  output logic tgt_valid_o,
  output logic tgt_write_o,
  output logic [`PSFW_ADDR_W-1:0] tgt_addr_o,
  output logic [31:0] tgt_wdata_o,
  input wire logic tgt_ready_i,
  input wire logic tgt_resp_valid_i,
  input wire logic [31:0] tgt_rdata_i
);
  // Software registers
  logic [31:0] group_member_mask; // Membership mask
  logic [`PSFW_DTAG_W-1:0] err_tag; // Logged doubled tag
  logic [`PSFW_ADDR_W-1:0] err_addr; // Logged address
  logic err_valid; // Error entry present
  logic err_write; // Logged direction
  logic err_ovfl; // Second error while entry held
  psfw_pkg::psfw_state_t state; // Access path state
  psfw_pkg::psfw_state_t next_state;
  logic [31:0] next_rdata;

  // Lookup result
  logic [`PSFW_DTAG_W-1:0] dtag;
  logic permit;

  psfw_check u_check (
    .initiator_tag_i(initiator_tag_i),
    .group_member_mask_i(group_member_mask),
    .doubled_initiator_tag_o(dtag),
    .permit_o(permit)
  );

  // Address decode helper
  function automatic logic psfw_hit(input logic [7:0] a, input logic [7:0] off);
    psfw_hit = (a == off);
  endfunction

  // Write strobes per register; the clock enable gates wr_mask in its process and wr_stat in clr_log
  wire wr_mask = reg_wr_i && psfw_hit(reg_addr_i, `PSFW_OFF_MEMBER);
  wire wr_stat = reg_wr_i && psfw_hit(reg_addr_i, `PSFW_OFF_ERR_STAT);
  // Software clear of the error entry this cycle
  wire clr_log = ce_i && wr_stat && reg_wdata_i[`PSFW_STAT_VALID];
  // Accepted request this cycle
  wire take = ce_i && acc_valid_i && state == psfw_pkg::PSFW_IDLE;
  wire deny = take && !permit; // R7
  wire fwd = take && permit; // R1

  // Read mux; unmapped offsets read zero
  // Status word packs valid, direction and overflow from bit 0 up
  wire [31:0] stat_word = {29'h0, err_ovfl, err_write, err_valid};
  assign next_rdata =
    psfw_hit(reg_addr_i, `PSFW_OFF_MEMBER) ? group_member_mask :
    psfw_hit(reg_addr_i, `PSFW_OFF_ERR_TAG) ? {27'h0, err_tag} :
    psfw_hit(reg_addr_i, `PSFW_OFF_ERR_STAT) ? stat_word :
    psfw_hit(reg_addr_i, `PSFW_OFF_ERR_ADDR) ? {16'h0, err_addr} : 32'h0000_0000;

  // Register read data, one cycle after strobe
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      reg_rdata_o <= 32'h0000_0000;
    else if (ce_i)
      reg_rdata_o <= reg_rd_i ? next_rdata : 32'h0000_0000;
  end

  // Membership mask; software programs grants
  // Upper half comes up clear, so doubled tags 16 and above are blocked
  // until software grants them
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      group_member_mask <= `PSFW_MEMBER_RST; // R4 R5
    else if (ce_i && wr_mask)
      group_member_mask <= reg_wdata_i; // R6
  end

  // Error log; a new violation wins over a clear
  // Only the first offender is kept so software sees the root cause;
  // later ones only raise the overflow flag
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      err_valid <= 1'b0;
      err_write <= 1'b0;
      err_ovfl <= 1'b0;
      err_tag <= 5'h0_0;
      err_addr <= 16'h0000;
    end
    else if (deny && !err_valid)
    begin
      // First violation captured
      err_valid <= 1'b1;
      err_write <= acc_write_i;
      err_tag <= dtag; // R3
      err_addr <= acc_addr_i;
    end
    else if (deny)
      err_ovfl <= 1'b1; // Entry kept, overflow flagged
    else if (clr_log)
    begin
      // Write one clears the entry
      err_valid <= 1'b0;
      err_ovfl <= 1'b0;
    end
  end

  // Next state of the access path
  always_comb
  begin
    next_state = state;
    case (state)
      psfw_pkg::PSFW_IDLE:
        if (fwd)
          next_state = psfw_pkg::PSFW_FWD;
        else if (deny)
          next_state = psfw_pkg::PSFW_DENY;
      psfw_pkg::PSFW_FWD:
        if (tgt_resp_valid_i)
          next_state = psfw_pkg::PSFW_IDLE;
      psfw_pkg::PSFW_DENY:
        next_state = psfw_pkg::PSFW_IDLE;
      default:
        next_state = psfw_pkg::PSFW_IDLE;
    endcase
  end

  // State and forwarded request
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      state <= psfw_pkg::PSFW_IDLE;
      tgt_valid_o <= 1'b0;
      tgt_write_o <= 1'b0;
      tgt_addr_o <= 16'h0000;
      tgt_wdata_o <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      state <= next_state;
      if (fwd)
      begin
        // Only permitted accesses reach the target
        tgt_valid_o <= 1'b1; // R1
        tgt_write_o <= acc_write_i;
        tgt_addr_o <= acc_addr_i;
        tgt_wdata_o <= acc_wdata_i;
      end
      else if (tgt_ready_i)
        tgt_valid_o <= 1'b0;
    end
  end

  // Response to the initiator
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      acc_resp_valid_o <= 1'b0;
      acc_resp_err_o <= 1'b0;
      acc_rdata_o <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      acc_resp_valid_o <= 1'b0;
      acc_resp_err_o <= 1'b0;
      if (state == psfw_pkg::PSFW_DENY)
      begin
        // Error answer, no data
        acc_resp_valid_o <= 1'b1; // R7
        acc_resp_err_o <= 1'b1; // R7
        acc_rdata_o <= 32'h0000_0000;
      end
      else if (state == psfw_pkg::PSFW_FWD && tgt_resp_valid_i)
      begin
        acc_resp_valid_o <= 1'b1;
        acc_rdata_o <= tgt_rdata_i;
      end
    end
  end

  // Request accepted only while idle
  // One access outstanding at a time keeps the response order trivial
  assign acc_ready_o = ce_i && state == psfw_pkg::PSFW_IDLE;

  // Checks
  AST_DENY_NOT_FORWARDED: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R7
    deny |=> !$rose(tgt_valid_o))
    else $error("denied access forwarded");
  AST_DENY_ERR_RESP: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R7
    deny ##1 ce_i |=> acc_resp_valid_o && acc_resp_err_o)
    else $error("no error response");
  AST_LOG_DOUBLED: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R3
    (deny && !err_valid) |=> err_valid && err_tag == {$past(initiator_tag_i), 1'b0})
    else $error("logged tag not doubled");
  AST_PERMIT_BIT: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R2
    take |-> permit == group_member_mask[{initiator_tag_i, 1'b0}])
    else $error("wrong mask bit");
  AST_FWD_PERMITTED: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R1
    fwd |=> tgt_valid_o && tgt_addr_o == $past(acc_addr_i))
    else $error("permitted access not forwarded");
  AST_RESET_MASK: assert property (@(posedge clk_i) // R4
    !rst_n_i |=> group_member_mask[31:16] == 16'h0000)
    else $error("mask upper half not zero");
  AST_HIGH_TAG_DENIED: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R5
    take && initiator_tag_i >= 4'h8 && group_member_mask == `PSFW_MEMBER_RST |-> deny)
    else $error("high tag allowed by default");
  AST_MASK_WRITE: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R6
    ce_i && wr_mask |=> group_member_mask == $past(reg_wdata_i))
    else $error("mask write lost");

  // Read data is zero outside the cycle after a read strobe
  AST_RDATA_IDLE_ZERO: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && !reg_rd_i |=> reg_rdata_o == 32'h0000_0000)
    else $error("read data not cleared");

  // Clock enable low freezes the mask
  AST_CE_FREEZE_MASK: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !ce_i |=> $stable(group_member_mask))
    else $error("mask moved while frozen");

  // Clock enable low freezes the access path
  AST_CE_FREEZE_STATE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !ce_i |=> $stable(state) && $stable(tgt_valid_o))
    else $error("access path moved while frozen");

  // Clock enable low freezes the error log
  AST_CE_FREEZE_LOG: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !ce_i |=> $stable(err_valid) && $stable(err_tag) && $stable(err_ovfl))
    else $error("error log moved while frozen");

  // No new request taken while one is outstanding
  AST_ONE_OUTSTANDING: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state != psfw_pkg::PSFW_IDLE |-> !acc_ready_o)
    else $error("request taken while busy");

  // Response lasts one cycle
  AST_RESP_PULSE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    acc_resp_valid_o && ce_i |=> !acc_resp_valid_o)
    else $error("response held too long");

  // Error flag only travels with a response and carries no data
  AST_ERR_WITH_RESP: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R7
    acc_resp_err_o |-> acc_resp_valid_o && acc_rdata_o == 32'h0000_0000)
    else $error("stray error flag");

  // A held entry keeps the first offender
  AST_LOG_HELD: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R3
    err_valid && !clr_log |=> err_valid && $stable(err_tag) && $stable(err_addr))
    else $error("logged entry overwritten");

  // A second violation raises overflow
  AST_OVFL_SET: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    deny && err_valid |=> err_ovfl)
    else $error("overflow not flagged");

  // Violation and clear in one cycle: the violation wins
  AST_SET_WINS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    deny && clr_log |=> err_valid)
    else $error("clear beat a violation");

  // Forwarded request stands until the target takes it
  AST_TGT_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    tgt_valid_o && !tgt_ready_i |=> tgt_valid_o)
    else $error("target request dropped");
endmodule

// file: hdl/psfw_pkg.sv
package psfw_pkg;
  // Access path state
  typedef enum logic [1:0] {
    PSFW_IDLE = 2'b00,
    PSFW_FWD = 2'b01,
    PSFW_DENY = 2'b10
  } psfw_state_t;
endpackage

// file: verif/psfw_tgt_model.sv
`timescale 1ns/10ps
// Target stand-in: takes a request, answers after a chosen delay
module psfw_tgt_model (
  input wire logic clk_i,
  input wire logic valid_i,
  input wire logic [15:0] addr_i,
  input wire logic [3:0] delay_i,
  output logic ready_o = 1'b0,
  output logic resp_o = 1'b0,
  output logic [31:0] rdata_o = 32'h0000_0000
);
  int cnt = -1; // Cycles left before the answer
  logic [15:0] addr_q; // Address of the held request
  // Accept, count down, answer once
  always @(posedge clk_i)
  begin
    ready_o <= 1'b0;
    resp_o <= 1'b0;
    rdata_o <= ~rdata_o; // Stale data never holds still
    if (valid_i && !ready_o && cnt < 0)
    begin
      ready_o <= 1'b1;
      cnt <= delay_i;
      addr_q <= addr_i;
    end
    else if (cnt == 0)
    begin
      resp_o <= 1'b1;
      rdata_o <= {16'hA5A5, addr_q};
      cnt <= -1;
    end
    else if (cnt > 0)
      cnt <= cnt - 1;
  end
endmodule

// file: verif/tb.sv
`timescale 1ns/10ps
`include "psfw_defines.svh"
// Firewall bench: queued expectations, monitor compares
module tb;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic ce_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0000_0000;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic acc_valid_i = 1'b0;
  logic acc_write_i = 1'b0;
  logic [3:0] initiator_tag_i = 4'h0;
  logic [15:0] acc_addr_i = 16'h0000;
  logic [31:0] acc_wdata_i = 32'h0000_0000;
  logic [3:0] dly = 4'h0; // Target answer delay
  logic [31:0] reg_rdata_o, acc_rdata_o, tgt_wdata_o, tgt_rdata_i;
  logic [15:0] tgt_addr_o;
  logic acc_ready_o, acc_resp_valid_o, acc_resp_err_o, tgt_valid_o, tgt_write_o;
  logic tgt_ready_i, tgt_resp_valid_i;
  logic rd_q = 1'b0; // Read strobe seen last edge
  logic [31:0] mask; // Bench copy of the membership mask
  logic [31:0] rq[$]; // Expected read data
  logic [33:0] aq[$]; // Expected {data valid, err, data}
  logic [33:0] e;
  int miscompares = 0;
  int num_checks = 0;
  int cyc = 0;
  psfw_firewall u_dut (.clk_i, .rst_n_i, .ce_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .acc_valid_i, .acc_write_i, .initiator_tag_i, .acc_addr_i,
    .acc_wdata_i, .acc_ready_o, .acc_resp_valid_o, .acc_resp_err_o, .acc_rdata_o,
    .tgt_valid_o, .tgt_write_o, .tgt_addr_o, .tgt_wdata_o, .tgt_ready_i, .tgt_resp_valid_i,
    .tgt_rdata_i);
  psfw_tgt_model u_tgt (.clk_i, .valid_i(tgt_valid_o), .addr_i(tgt_addr_o), .delay_i(dly),
    .ready_o(tgt_ready_i), .resp_o(tgt_resp_valid_i), .rdata_o(tgt_rdata_i));
  // Clock
  always #12.5 clk_i = ~clk_i;
  // Compare one result
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Counts and verdict
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Register write, then a gap cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // Register read with expected data queued
  task automatic rd(input logic [7:0] a, input logic [31:0] d);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    rq.push_back(d);
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // One access of the given direction, held until taken, then wait for answer
  task automatic acc(input logic [3:0] t, input logic [15:0] a, input logic w);
    int n = 0;
    acc_valid_i <= 1'b1;
    acc_write_i <= w;
    initiator_tag_i <= t;
    acc_addr_i <= a;
    acc_wdata_i <= $urandom;
    dly <= 4'($urandom_range(0, 6));
    aq.push_back({mask[2*t], !mask[2*t], 16'hA5A5, a});
    @(negedge clk_i);
    while (acc_ready_o !== 1'b1 && n < 50)
    begin
      @(negedge clk_i);
      n++;
    end
    @(posedge clk_i);
    acc_valid_i <= 1'b0;
    while (aq.size() > 0 && n < 90)
    begin
      @(posedge clk_i);
      n++;
    end
  endtask
  // Every tag once, then the error log and its clear
  task automatic sweep;
    logic [15:0] a, fa;
    logic [4:0] ft;
    logic w, fw;
    int nd = 0;
    for (int t = 0; t < 16; t++)
    begin
      a = $urandom;
      w = $urandom;
      if (!mask[2*t] && nd++ == 0)
      begin
        ft = 5'(2 * t);
        fa = a;
        fw = w;
      end
      acc(4'(t), a, w);
    end
    rd(`PSFW_OFF_ERR_TAG, {27'h0, ft});
    rd(`PSFW_OFF_ERR_STAT, {29'h0, nd > 1, fw, 1'b1});
    rd(`PSFW_OFF_ERR_ADDR, {16'h0, fa});
    wr(`PSFW_OFF_ERR_STAT, 32'h0000_0001);
    rd(`PSFW_OFF_ERR_STAT, 32'h0000_0000);
  endtask
  // Monitor: takes the oldest note as each result appears
  always @(posedge clk_i)
  begin
    rd_q <= reg_rd_i;
    cyc <= cyc + 1;
    if (rd_q)
      chk(reg_rdata_o, rq.pop_front());
    if (tgt_valid_o === 1'b1)
    begin
      chk({31'h0, mask[2*initiator_tag_i]}, 32'h0000_0001);
      chk({15'h0, tgt_write_o, tgt_addr_o}, {15'h0, acc_write_i, acc_addr_i});
      chk(tgt_wdata_o, acc_wdata_i);
    end
    if (acc_resp_valid_o === 1'b1)
    begin
      e = aq.pop_front();
      chk({31'h0, acc_resp_err_o}, {31'h0, e[32]});
      if (e[33])
        chk(acc_rdata_o, e[31:0]);
    end
    if (cyc == 6000)
    begin
      miscompares++;
      end_of_test();
    end
  end
  // Main sequence
  initial
  begin
    void'($urandom(34));
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    ce_i <= 1'b0;
    wr(`PSFW_OFF_MEMBER, 32'h0000_0000);
    ce_i <= 1'b1;
    rd(`PSFW_OFF_MEMBER, 32'h0000_FFFF);
    rd(`PSFW_OFF_ERR_STAT, 32'h0000_0000);
    rd(8'h10, 32'h0000_0000);
    $display("test reset done");
    mask = 32'h0000_FFFF;
    sweep();
    $display("test default mask done");
    mask = ($urandom | 32'h0100_0000) & ~32'h0000_0004;
    wr(`PSFW_OFF_MEMBER, mask);
    wr(8'h14, ~mask);
    rd(`PSFW_OFF_MEMBER, mask);
    sweep();
    $display("test programmed mask done");
    end_of_test();
  end
endmodule
